//--- logic/psc_defines.vh
// register map, field positions, reset values and clock periods in ns for the supply controller
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
// ---------------------------------------------------------------
// slave address and register map
// ---------------------------------------------------------------
`define PSC_SLAVE_ADDR      7'h5a
`define PSC_REG_SEL_W       3
`define PSC_OFF_ENABLE      3'h0
`define PSC_OFF_STATUS      3'h1
`define PSC_OFF_BUCK        3'h2
`define PSC_OFF_LIN1        3'h3
`define PSC_OFF_LIN2        3'h4
// ---------------------------------------------------------------
// enable register fields
// ---------------------------------------------------------------
`define PSC_EN_BUCK_BIT     0
`define PSC_EN_LIN1_BIT     1
`define PSC_EN_LIN2_BIT     2
`define PSC_EN_INHIBIT_BIT  4
`define PSC_EN_RESTART_BIT  5
`define PSC_EN_WMASK        8'h37
// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define PSC_ST_OVERHEAT_BIT 4
`define PSC_ST_LOWIN_BIT    5
`define PSC_ST_IRQEN_BIT    6
// ---------------------------------------------------------------
// reset and default values
// ---------------------------------------------------------------
`define PSC_RESTART_RST     1'b1
`define PSC_DEF_SUPPLIES    3'h7
`define PSC_DEF_BUCK_CODE   8'h1c
`define PSC_DEF_LIN1_CODE   8'h45
`define PSC_DEF_LIN2_CODE   8'hd1
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PSC_CLK_NS          40
`define PSC_LINK_CLK_NS     320
`endif

//--- logic/psc_edge_sync.v
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
module psc_edge_sync (
  mclk,
  reset,
  ce,
  din,
  level_q,
  rise_q,
  fall_q
);
  input  wire mclk;
  input  wire reset;
  input  wire ce;
  input  wire din;
  output reg  level_q;
  output reg  rise_q;
  output reg  fall_q;

  reg meta_q;
  reg sync_q;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else if (ce) begin
      meta_q  <= din;
      sync_q  <= meta_q;
      level_q <= sync_q;
      rise_q  <= sync_q & ~level_q;
      fall_q  <= ~sync_q & level_q;
    end
  end
endmodule // psc_edge_sync

//--- logic/psc_chain.v
// power-good chained sequencer for three supplies
`timescale 1ns/1ps
module psc_chain (
  mclk,
  reset,
  ce,
  enables,
  inhibit,
  kill,
  valid,
  drive_q
);
  input  wire       mclk;
  input  wire       reset;
  input  wire       ce;
  input  wire [2:0] enables;
  input  wire       inhibit;
  input  wire       kill;
  input  wire [2:0] valid;
  output reg  [2:0] drive_q;

  // order: index 0 buck, 1 first linear, 2 second linear
  wire [2:0] ahead_ok;
  wire [2:0] up_new;
  reg  [2:0] en_prev_q;
  genvar g;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_link
      if (g == 0) begin : g_first
        assign ahead_ok[g] = 1'b1;
        assign up_new[g]   = 1'b0;
      end else begin : g_rest
        // next supply waits on power good of every enabled supply ahead
        assign ahead_ok[g] = &(valid[g-1:0] | ~enables[g-1:0]);
        // only supplies ahead restart a supply, so the first one switches freely
        assign up_new[g]   = |(enables[g-1:0] & ~en_prev_q[g-1:0]);
      end
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          drive_q[g] <= 1'b0;
        end else if (ce) begin
          if (kill || !enables[g]) begin
            drive_q[g] <= 1'b0;
          end else if (inhibit) begin
            drive_q[g] <= 1'b1;
          end else if (up_new[g]) begin
            drive_q[g] <= 1'b0; // upstream newly added: restart
          end else begin
            drive_q[g] <= ahead_ok[g] | drive_q[g];
          end
        end
      end
    end
  endgenerate

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      en_prev_q <= 3'h0;
    end else if (ce) begin
      en_prev_q <= enables;
    end
  end
endmodule // psc_chain

//--- logic/psc_top.v
// supply controller: serial register slave, fault handling and sequencing
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_top (
  mclk,
  reset,
  ce,
  scl,
  sda_in,
  sda_out,
  sda_oe_n,
  startup_pin,
  low_input_flag,
  overheat_flag,
  buck_valid,
  first_linear_valid,
  second_linear_valid,
  buck_drive,
  first_linear_drive,
  second_linear_drive,
  buck_code,
  first_linear_code,
  second_linear_code,
  fault_irq_out,
  fault_irq_oe_n
);
  input  wire       mclk;
  input  wire       reset;
  input  wire       ce;
  input  wire       scl;
  input  wire       sda_in;
  output reg        sda_out;
  output reg        sda_oe_n;
  input  wire       startup_pin;
  input  wire       low_input_flag;
  input  wire       overheat_flag;
  input  wire       buck_valid;
  input  wire       first_linear_valid;
  input  wire       second_linear_valid;
  output reg        buck_drive;
  output reg        first_linear_drive;
  output reg        second_linear_drive;
  output reg  [7:0] buck_code;
  output reg  [7:0] first_linear_code;
  output reg  [7:0] second_linear_code;
  output reg        fault_irq_out;
  output reg        fault_irq_oe_n;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  wire scl_s, scl_rise, scl_fall;
  wire sda_s, sda_rise, sda_fall;
  wire pin_rise, pin_fall;
  wire low_s, hot_s;
  wire bv_s, l1v_s, l2v_s;

  psc_edge_sync u_scl (.mclk(mclk), .reset(reset), .ce(ce), .din(scl),
    .level_q(scl_s), .rise_q(scl_rise), .fall_q(scl_fall));
  psc_edge_sync u_sda (.mclk(mclk), .reset(reset), .ce(ce), .din(sda_in),
    .level_q(sda_s), .rise_q(sda_rise), .fall_q(sda_fall));
  psc_edge_sync u_pin (
    .mclk    (mclk),
    .reset   (reset),
    .ce      (ce),
    .din     (startup_pin),
    .level_q (),
    .rise_q  (pin_rise),
    .fall_q  (pin_fall)
  );
  psc_edge_sync u_low (.mclk(mclk), .reset(reset), .ce(ce), .din(low_input_flag),
    .level_q(low_s), .rise_q(), .fall_q());
  psc_edge_sync u_hot (.mclk(mclk), .reset(reset), .ce(ce), .din(overheat_flag),
    .level_q(hot_s), .rise_q(), .fall_q());
  psc_edge_sync u_bv (.mclk(mclk), .reset(reset), .ce(ce), .din(buck_valid),
    .level_q(bv_s), .rise_q(), .fall_q());
  psc_edge_sync u_l1v (.mclk(mclk), .reset(reset), .ce(ce), .din(first_linear_valid),
    .level_q(l1v_s), .rise_q(), .fall_q());
  psc_edge_sync u_l2v (.mclk(mclk), .reset(reset), .ce(ce), .din(second_linear_valid),
    .level_q(l2v_s), .rise_q(), .fall_q());

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [2:0] supplies_q;
  reg       chain_inhibit_q;
  reg       restart_after_fault_q;
  reg       irq_en_q;
  reg       low_flag_q;
  reg       hot_flag_q;
  reg       fault_prev_q;

  wire fault_now   = low_s | hot_s;
  wire fault_rise  = fault_now & ~fault_prev_q;
  wire [2:0] valid_v = {l2v_s, l1v_s, bv_s};

  // ---------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_REG  = 6'h04;
  localparam [5:0] ST_DATA = 6'h08;
  localparam [5:0] ST_READ = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;

  reg [5:0] state_q;
  reg [7:0] shift_q;
  reg [3:0] bit_q;
  reg       ack_q;
  reg [2:0] reg_sel_q;
  reg       is_read_q;
  reg       wr_stb;
  reg [7:0] wr_data;
  reg [7:0] rd_data;

  wire start_cond = sda_fall & scl_s;
  wire stop_cond  = sda_rise & scl_s;

  // read multiplexer, reserved bits zero
  always @* begin
    case (reg_sel_q)
      `PSC_OFF_ENABLE: rd_data = {2'h0, restart_after_fault_q, chain_inhibit_q, 1'b0, supplies_q};
      `PSC_OFF_STATUS: rd_data = {1'b0, irq_en_q, low_flag_q, hot_flag_q, 1'b0, valid_v};
      `PSC_OFF_BUCK:   rd_data = buck_code;
      `PSC_OFF_LIN1:   rd_data = first_linear_code;
      `PSC_OFF_LIN2:   rd_data = second_linear_code;
      default:         rd_data = 8'h00;
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      shift_q   <= 8'h00;
      bit_q     <= 4'h0;
      ack_q     <= 1'b0;
      reg_sel_q <= 3'h0;
      is_read_q <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe_n  <= 1'b1;
      wr_stb    <= 1'b0;
      wr_data   <= 8'h00;
    end else if (ce) begin
      wr_stb <= 1'b0;
      if (start_cond) begin
        state_q  <= ST_ADDR; // repeated start allowed
        bit_q    <= 4'h0;
        ack_q    <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state_q  <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise && !ack_q && state_q != ST_READ && state_q != ST_IDLE) begin
        shift_q <= {shift_q[6:0], sda_s};
        bit_q   <= bit_q + 4'h1;
      end else if (scl_rise && ack_q && state_q == ST_RACK) begin
        // master ack low continues, nack ends the read
        if (sda_s) begin
          state_q <= ST_IDLE;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q    <= 1'b0;
          sda_oe_n <= 1'b1;
          bit_q    <= 4'h0;
          if (state_q == ST_READ || state_q == ST_RACK) begin
            state_q  <= ST_READ;
            shift_q  <= rd_data;
            sda_out  <= rd_data[7];
            sda_oe_n <= ~rd_data[7] ? 1'b0 : 1'b1;
          end
        end else if (state_q == ST_READ) begin
          if (bit_q == 4'h7) begin
            state_q  <= ST_RACK;
            ack_q    <= 1'b1;
            sda_oe_n <= 1'b1;
          end else begin
            bit_q    <= bit_q + 4'h1;
            shift_q  <= {shift_q[6:0], 1'b0};
            sda_out  <= shift_q[6];
            sda_oe_n <= shift_q[6];
          end
        end else if (bit_q == 4'h8) begin
          case (state_q)
            ST_ADDR: begin
              if (shift_q[7:1] == `PSC_SLAVE_ADDR) begin
                ack_q     <= 1'b1;
                sda_out   <= 1'b0;
                sda_oe_n  <= 1'b0;
                is_read_q <= shift_q[0];
                state_q   <= shift_q[0] ? ST_READ : ST_REG;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_REG: begin
              reg_sel_q <= shift_q[`PSC_REG_SEL_W-1:0];
              ack_q     <= 1'b1;
              sda_out   <= 1'b0;
              sda_oe_n  <= 1'b0;
              state_q   <= ST_DATA;
            end
            ST_DATA: begin
              wr_stb   <= 1'b1; // store at acknowledge
              wr_data  <= shift_q;
              ack_q    <= 1'b1;
              sda_out  <= 1'b0;
              sda_oe_n <= 1'b0;
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers, faults and startup pin
  // ---------------------------------------------------------------
  wire wr_en = wr_stb && reg_sel_q == `PSC_OFF_ENABLE;
  wire wr_st = wr_stb && reg_sel_q == `PSC_OFF_STATUS;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      supplies_q            <= 3'h0;
      chain_inhibit_q       <= 1'b0;
      restart_after_fault_q <= `PSC_RESTART_RST;
      irq_en_q              <= 1'b0;
      low_flag_q            <= 1'b0;
      hot_flag_q            <= 1'b0;
      fault_prev_q          <= 1'b0;
      buck_code             <= `PSC_DEF_BUCK_CODE;
      first_linear_code     <= `PSC_DEF_LIN1_CODE;
      second_linear_code    <= `PSC_DEF_LIN2_CODE;
    end else if (ce) begin
      fault_prev_q <= fault_now;
      // sticky flags: set wins over echo clear
      low_flag_q <= low_s | (low_flag_q & ~(wr_st & wr_data[`PSC_ST_LOWIN_BIT]));
      hot_flag_q <= hot_s | (hot_flag_q & ~(wr_st & wr_data[`PSC_ST_OVERHEAT_BIT]));
      if (wr_st) begin
        irq_en_q <= wr_data[`PSC_ST_IRQEN_BIT];
      end
      if (fault_rise) begin
        // codes reset to defaults, supplies to defaults only when restart is set, outputs held off while fault lasts
        chain_inhibit_q    <= 1'b0;
        supplies_q         <= restart_after_fault_q ? `PSC_DEF_SUPPLIES : 3'h0;
        buck_code          <= `PSC_DEF_BUCK_CODE;
        first_linear_code  <= `PSC_DEF_LIN1_CODE;
        second_linear_code <= `PSC_DEF_LIN2_CODE;
      end else if (pin_rise) begin
        // edge only, defaults then default startup
        chain_inhibit_q       <= 1'b0;
        supplies_q            <= `PSC_DEF_SUPPLIES;
        restart_after_fault_q <= `PSC_RESTART_RST;
        buck_code             <= `PSC_DEF_BUCK_CODE;
        first_linear_code     <= `PSC_DEF_LIN1_CODE;
        second_linear_code    <= `PSC_DEF_LIN2_CODE;
      end else if (pin_fall) begin
        supplies_q <= 3'h0;
      end else if (wr_stb) begin
        case (reg_sel_q)
          `PSC_OFF_ENABLE: begin
            supplies_q            <= wr_data[2:0];
            chain_inhibit_q       <= wr_data[`PSC_EN_INHIBIT_BIT];
            restart_after_fault_q <= wr_data[`PSC_EN_RESTART_BIT];
          end
          `PSC_OFF_BUCK: buck_code <= wr_data;
          `PSC_OFF_LIN1: first_linear_code <= wr_data;
          `PSC_OFF_LIN2: second_linear_code <= wr_data;
          default: begin
            supplies_q <= supplies_q;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer and outputs
  // ---------------------------------------------------------------
  wire [2:0] drive_w;
  // a pin fall clears the chain too, so no drive comes back for a cycle
  wire       chain_kill = fault_now | pin_fall;

  psc_chain u_chain (
    .mclk    (mclk),
    .reset   (reset),
    .ce      (ce),
    .enables (supplies_q),
    .inhibit (chain_inhibit_q),
    .kill    (chain_kill),
    .valid   (valid_v),
    .drive_q (drive_w)
  );

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      buck_drive          <= 1'b0;
      first_linear_drive  <= 1'b0;
      second_linear_drive <= 1'b0;
      fault_irq_out       <= 1'b0;
      fault_irq_oe_n      <= 1'b1;
    end else if (ce) begin
      // all three supply drives off at once on fault or pin fall
      buck_drive          <= drive_w[0] & ~fault_now & ~pin_fall;
      first_linear_drive  <= drive_w[1] & ~fault_now & ~pin_fall;
      second_linear_drive <= drive_w[2] & ~fault_now & ~pin_fall;
      fault_irq_out       <= 1'b0;
      fault_irq_oe_n      <= ~(irq_en_q & (low_flag_q | hot_flag_q));
    end
  end
endmodule // psc_top

//--- verif/psc_top_monitor.sv
// port checker for the supply controller
`timescale 1ns/1ps
module psc_monitor (
  mclk,
  reset,
  scl,
  startup_pin,
  low_input_flag,
  overheat_flag,
  sda_out,
  sda_oe_n,
  buck_drive,
  first_linear_drive,
  second_linear_drive,
  buck_code,
  first_linear_code,
  second_linear_code,
  fault_irq_oe_n
);
  input wire       mclk, reset, scl, startup_pin, low_input_flag, overheat_flag;
  input wire       sda_out, sda_oe_n, buck_drive, first_linear_drive, second_linear_drive;
  input wire       fault_irq_oe_n;
  input wire [7:0] buck_code, first_linear_code, second_linear_code;
  logic      [3:0] fault_age_q;
  wire             fault_any = low_input_flag | overheat_flag;
  // cycles since a fault level was last seen, saturating
  always @(posedge mclk or posedge reset) begin
    if (reset) fault_age_q <= 4'hf;
    else if (fault_any) fault_age_q <= 4'h0;
    else if (fault_age_q != 4'hf) fault_age_q <= fault_age_q + 4'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence supplies_off;
    !buck_drive && !first_linear_drive && !second_linear_drive;
  endsequence
  sequence fault_held;
    fault_any [*5];
  endsequence
  chk_sda_low_only: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
  chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data line changed with serial clock high");
  chk_sda_stand: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
    else $error("data line low bit too short");
  chk_fault_off: assert property (fault_held |-> supplies_off)
    else $error("supply on during fault");
  chk_irq_cause: assert property ($fell(fault_irq_oe_n) |-> fault_age_q < 4'h8 || !scl)
    else $error("interrupt without fault");
  chk_startup_fall: assert property ($fell(startup_pin) |-> ##[1:5] supplies_off)
    else $error("supplies not off after startup pin fall");
  chk_startup_rise: assert property ($rose(startup_pin) && !fault_any |-> ##[2:8] buck_drive)
    else $error("buck not started after startup pin rise");
  chk_reset_state: assert property ($fell(reset) |-> supplies_off ##0 (buck_code == 8'h1c
    && first_linear_code == 8'h45 && second_linear_code == 8'hd1 && sda_oe_n && fault_irq_oe_n))
    else $error("wrong state after reset");
endmodule // psc_monitor
bind psc_top psc_monitor u_mon (.mclk, .reset, .scl, .startup_pin, .low_input_flag,
  .overheat_flag, .sda_out, .sda_oe_n, .buck_drive, .first_linear_drive, .second_linear_drive,
  .buck_code, .first_linear_code, .second_linear_code, .fault_irq_oe_n);

//--- verif/psc_i2c_host.sv
// serial host model for the register bus, 2.56 us bit period
`timescale 1ns/1ps
module psc_i2c_host (
  scl,
  sda_pull_low,
  sda_line
);
  output logic scl;
  output logic sda_pull_low;
  input  wire  sda_line;
  initial begin
    scl = 1'b1;
    sda_pull_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #640 sda_pull_low = ~b;
    #640 scl = 1'b1;
    #640 r = sda_line;
    #640 scl = 1'b0;
  endtask
  task automatic start_cond();
    #640 sda_pull_low = 1'b0;
    #640 scl = 1'b1;
    #640 sda_pull_low = 1'b1;
    #640 scl = 1'b0;
  endtask
  task automatic stop_cond();
    #640 sda_pull_low = 1'b1;
    #640 scl = 1'b1;
    #640 sda_pull_low = 1'b0;
    #640;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(1'b1, b);
    ack = ~b;
  endtask
  // byte write, or byte read through a repeated start ending with no acknowledge
  task automatic xfer(input logic [6:0] dev, input logic rdn, input logic [7:0] sel,
                      input logic [7:0] wd, output logic [7:0] rdata, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, held;
    start_cond();
    byte_io({dev, 1'b0}, r, a0);
    byte_io(sel, r, a1);
    if (rdn) begin
      start_cond();
      byte_io({dev, 1'b1}, r, a2);
      byte_io(8'hff, rdata, held);
    end else begin
      byte_io(wd, r, a2);
      held = 1'b0;
    end
    stop_cond();
    ok = a0 & a1 & a2 & ~held;
  endtask
endmodule // psc_i2c_host

//--- verif/pmic_supply_control_regs_tb_top.sv
// self-checking bench for the supply controller
`timescale 1ns/1ps
module pmic_supply_control_regs_tb_top;
  logic        mclk, reset, startup_pin, low_input_flag, overheat_flag, ok, dropped;
  logic [2:0]  pg_block;
  logic [11:0] pg_q;
  logic [7:0]  rd, v;
  logic [7:0]  lin_tbl [5] = '{8'h00, 8'h45, 8'h85, 8'hd1, 8'he8};
  int          num_errors, checks;
  wire         scl, host_low, sda_out, sda_oe_n, fault_irq_out, fault_irq_oe_n;
  wire         buck_drive, first_linear_drive, second_linear_drive;
  wire [7:0]   buck_code, first_linear_code, second_linear_code;
  wire [2:0]   drives = {second_linear_drive, first_linear_drive, buck_drive};
  wire [2:0]   valid = pg_q[11:9] & drives & ~pg_block;
  wire         sda_line = (sda_oe_n | sda_out) & ~host_low;
  psc_top DUT (.mclk, .reset, .ce(1'b1), .scl, .sda_in(sda_line), .sda_out, .sda_oe_n,
    .startup_pin, .low_input_flag, .overheat_flag, .buck_valid(valid[0]),
    .first_linear_valid(valid[1]), .second_linear_valid(valid[2]), .buck_drive,
    .first_linear_drive, .second_linear_drive, .buck_code, .first_linear_code,
    .second_linear_code, .fault_irq_out, .fault_irq_oe_n);
  psc_i2c_host u_host (.scl, .sda_pull_low(host_low), .sda_line);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // power good trails each drive by four cycles unless held back
  always @(posedge mclk) begin
    pg_q <= {pg_q[8:0], drives};
    if (!second_linear_drive) dropped <= 1'b1;
  end
  function automatic logic [7:0] por(input int i);
    return i == 0 ? 8'h20 : i == 2 ? 8'h1c : i == 3 ? 8'h45 : i == 4 ? 8'hd1 : 8'h00;
  endfunction
  function automatic logic [7:0] stat(input logic ie, lo, hot, input logic [2:0] pv);
    return {1'b0, ie, lo, hot, 1'b0, pv};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] sel, input logic [7:0] d);
    u_host.xfer(7'h5a, 1'b0, sel, d, rd, ok);
    cmp({7'h00, ok}, 8'h01);
    tick(1);
  endtask
  task automatic rdc(input logic [7:0] sel, input logic [7:0] e);
    u_host.xfer(7'h5a, 1'b1, sel, 8'h00, rd, ok);
    cmp({7'h00, ok}, 8'h01);
    cmp(rd, e);
    tick(1);
  endtask
  task automatic wait_drv(input logic [2:0] e);
    for (int i = 0; i < 300 && drives !== e; i++) tick(1);
    cmp({5'h00, drives}, {5'h00, e});
  endtask
  task automatic conclude();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #3_900_000;
    num_errors++;
    conclude();
  end
  initial begin
    {reset, startup_pin, low_input_flag, overheat_flag, dropped} = 5'b10000;
    pg_block = 3'b000;
    num_errors = 0;
    checks = 0;
    void'($urandom(32'h8900e0ee));
    tick(12);
    reset = 1'b0;
    tick(4);
    for (int i = 0; i < 8; i++) rdc({5'($urandom), 3'(i)}, por(i));
    u_host.xfer(7'h5b, 1'b0, 8'h00, 8'h07, rd, ok);
    cmp({7'h00, ok}, 8'h00);
    pg_block = 3'b001;
    wr(8'h00, 8'h23);
    tick(40);
    cmp({5'h00, drives}, 8'h01);
    pg_block = 3'b000;
    wait_drv(3'b011);
    rdc(8'h01, stat(1'b0, 1'b0, 1'b0, 3'b011));
    for (int j = 2; j < 5; j++) begin
      v = (j == 2) ? 8'($urandom % 29) : lin_tbl[$urandom % 5];
      wr(8'(j), v);
      cmp(j == 2 ? buck_code : j == 3 ? first_linear_code : second_linear_code, v);
      rdc(8'(j), v);
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 8'h30);
      wait_drv(3'b000);
      wr(8'h00, 8'h25 | 8'(k << 4));
      wait_drv(3'b101);
      dropped = 1'b0;
      wr(8'h00, 8'h27 | 8'(k << 4));
      wait_drv(3'b111);
      cmp({7'h00, dropped}, {7'h00, k == 0});
    end
    wr(8'h00, 8'h30);
    startup_pin = 1'b1;
    wait_drv(3'b001);
    wait_drv(3'b011);
    wait_drv(3'b111);
    cmp(second_linear_code, 8'hd1);
    rdc(8'h00, 8'h27);
    wr(8'h00, 8'h37);
    wr(8'h00, 8'h30);
    tick(50);
    cmp({5'h00, drives}, 8'h00);
    startup_pin = 1'b0;
    tick(8);
    startup_pin = 1'b1;
    wait_drv(3'b111);
    startup_pin = 1'b0;
    wait_drv(3'b000);
    rdc(8'h00, 8'h20);
    wr(8'h01, 8'hff);
    rdc(8'h01, stat(1'b1, 1'b0, 1'b0, 3'b000));
    wr(8'h00, 8'h27);
    wait_drv(3'b111);
    wr(8'h02, 8'h05);
    overheat_flag = 1'b1;
    wait_drv(3'b000);
    tick(4);
    cmp({6'h00, fault_irq_out, fault_irq_oe_n}, 8'h00);
    cmp(buck_code, 8'h1c);
    overheat_flag = 1'b0;
    wait_drv(3'b111);
    rdc(8'h01, stat(1'b1, 1'b0, 1'b1, 3'b111));
    wr(8'h01, 8'h50);
    rdc(8'h01, stat(1'b1, 1'b0, 1'b0, 3'b111));
    cmp({6'h00, fault_irq_out, fault_irq_oe_n}, 8'h01);
    wr(8'h00, 8'h17);
    low_input_flag = 1'b1;
    wait_drv(3'b000);
    wr(8'h01, 8'h60);
    rdc(8'h01, stat(1'b1, 1'b1, 1'b0, 3'b000));
    rdc(8'h00, 8'h00);
    low_input_flag = 1'b0;
    tick(40);
    cmp({5'h00, drives}, 8'h00);
    conclude();
  end
endmodule // pmic_supply_control_regs_tb_top
